// ===== rtl/mse_params.svh
// Purpose: Offsets, field positions and reset values of the skip/subtract/table/xor unit
// Assumes: Wishbone byte addresses, 32-bit data, one aligned word per register
// Notes: Included by the unit and the testbench
`ifndef MSE_PARAMS_SVH
`define MSE_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define MSE_ADR_CMD 12'h000
`define MSE_ADR_ACC 12'h004
`define MSE_ADR_FLAGS 12'h008
`define MSE_ADR_TPL 12'h00C
`define MSE_ADR_TPH 12'h010
`define MSE_ADR_TBH 12'h014
`define MSE_ADR_STAT 12'h018
`define MSE_ADR_PADDR 12'h01C
`define MSE_ADR_PDATA 12'h020
`define MSE_DWIN_SEL 2'h1

// ---------------------------------------------------------------
// Flag and status bit positions
// ---------------------------------------------------------------
`define MSE_FLG_CARRY 0
`define MSE_FLG_HALF 1
`define MSE_FLG_ZERO 2
`define MSE_FLG_WRAP 3
`define MSE_FLG_SCMP 4
`define MSE_FLG_CHZ 5
`define MSE_STAT_BUSY 0
`define MSE_STAT_SKIP 1
`define MSE_STAT_DUMMY 2

// ---------------------------------------------------------------
// Sizes and reset values
// ---------------------------------------------------------------
`define MSE_DMEM_WORDS 256
`define MSE_PMEM_WORDS 1024
`define MSE_FINAL_PAGE 2'h3
`define MSE_RST_BYTE 8'h00
`define MSE_RST_FLAGS 6'h00

`endif

// ===== rtl/mse_pkg.sv
// Purpose: Types shared by the skip/subtract/table/xor unit
// Assumes: Operation codes follow declaration order, starting at 0
// Notes: Codes above the last entry execute as no operation
`default_nettype none

package mse_pkg;
	typedef enum logic [4:0] {
		op_set_bit,
		op_skip_on_increment_zero,
		op_increment_to_accumulator_skip,
		op_skip_when_bit_nonzero,
		op_skip_when_nonzero,
		op_skip_when_zero,
		op_copy_then_skip_when_zero,
		op_skip_when_bit_zero,
		op_difference_to_accumulator,
		op_difference_to_memory,
		op_difference_immediate,
		op_nibble_exchange,
		op_nibble_exchange_to_accumulator,
		op_table_read_paged,
		op_table_read_final_page,
		op_preincrement_table_read_paged,
		op_preincrement_table_read_final,
		op_exclusive_or_to_accumulator,
		op_exclusive_or_to_memory,
		op_exclusive_or_immediate
	} mse_op_e;

	typedef enum logic [1:0] {
		st_idle,
		st_exec,
		st_dummy
	} mse_state_e;

	typedef logic [7:0] mse_byte_t;
	typedef logic [5:0] mse_flags_t;
endpackage : mse_pkg

`default_nettype wire

// ===== rtl/mse_exec.sv
// Purpose: Executes skip, bit set, subtract, nibble swap, table read and xor operations
// Assumes: One clock, synchronous active-high reset, classic Wishbone slave
// Notes: Data and program memories live inside; software loads and inspects them over the bus
//
// Summary of operation
// - Bit set forces one selected memory bit high, other bits and flags untouched.
// - Increment memory byte, write back, skip next when the sum is zero.
// - A skip inserts one dummy cycle, so skipping takes two cycles.
// - Increment variant puts sum in accumulator, memory kept, skips on zero.
// - Skip when the selected bit of the byte is one.
// - Read and rewrite byte unchanged; skip when it is nonzero.
// - Read and rewrite byte unchanged; skip only when it is zero.
// - Copy byte into accumulator; skip when that byte is zero.
// - Skip when the selected bit of the byte is zero.
// - Subtract operand from accumulator: memory to acc, memory to memory, immediate.
// - Subtraction carry clears on negative result, sets on zero or positive.
// - Subtraction updates wrap, zero, half carry, carry, signed compare, chained zero.
// - Nibble exchange swaps byte halves in place, no flags touched.
// - Nibble exchange variant writes swapped byte to accumulator, memory kept.
// - Paged table read uses both pointer bytes; low to memory, high to latch.
// - Final page table read uses low pointer only on the last page.
// - Preincrement paged read bumps low pointer first, then reads paged.
// - Preincrement final read bumps low pointer first, then reads last page.
// - Xor accumulator with memory or immediate; result to acc or memory; zero flag only.
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "mse_params.svh"
`default_nettype none

module mse_exec
	import mse_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [11:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Sequencing status
	output logic busy_out,
	output logic skip_fetch_out,
	output logic done_out
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	mse_byte_t dmem [0:`MSE_DMEM_WORDS-1];
	logic [15:0] pmem [0:`MSE_PMEM_WORDS-1];
	mse_state_e state_reg;
	mse_byte_t cmd_op_reg, cmd_bit_reg, cmd_addr_reg, cmd_imm_reg;
	mse_byte_t acc_reg, tpl_reg, tph_reg, tbh_reg;
	mse_flags_t flags_reg;
	logic [9:0] paddr_reg;
	logic ack_reg, skip_reg, done_reg;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	logic bus_req, wr_go, in_dwin, start_cmd;
	logic [7:0] dwin_idx;
	assign bus_req = wb_cyc_in & wb_stb_in;
	// Writes are held off while an operation runs, so bus and core never race on state
	assign wr_go = bus_req & wb_we_in & ack_reg;
	assign in_dwin = (wb_adr_in[11:10] == `MSE_DWIN_SEL);
	assign dwin_idx = wb_adr_in[9:2];
	assign start_cmd = wr_go & (wb_adr_in == `MSE_ADR_CMD) & wb_sel_in[0];
	function automatic mse_byte_t lane(input mse_byte_t old_v, input logic en, input mse_byte_t new_v);
		lane = en ? new_v : old_v;
	endfunction : lane
	// ---------------------------------------------------------------
	// Operation datapath
	// ---------------------------------------------------------------
	mse_op_e op;
	mse_byte_t mem_rd, inc_val, sub_opnd, sub_res, swap_val, tpl_eff;
	logic [8:0] diff9;
	logic [4:0] half5;
	logic [9:0] tab_addr;
	logic [15:0] prog_word;
	logic sel_bit, is_sub, is_tab, is_pre, is_final;
	logic mem_we, acc_we, flags_we, skip_hit;
	mse_byte_t mem_wd, acc_wd;
	mse_flags_t flags_wd;
	assign op = mse_op_e'(cmd_op_reg[4:0]);
	assign mem_rd = dmem[cmd_addr_reg];
	assign sel_bit = mem_rd[cmd_bit_reg[2:0]];
	assign inc_val = mem_rd + 8'h01;
	assign is_sub = (op == op_difference_to_accumulator) | (op == op_difference_to_memory)
		| (op == op_difference_immediate);
	assign sub_opnd = (op == op_difference_immediate) ? cmd_imm_reg : mem_rd;
	assign diff9 = {1'b0, acc_reg} - {1'b0, sub_opnd};
	assign half5 = {1'b0, acc_reg[3:0]} - {1'b0, sub_opnd[3:0]};
	assign sub_res = diff9[7:0];
	assign swap_val = {mem_rd[3:0], mem_rd[7:4]};
	assign is_tab = (op == op_table_read_paged) | (op == op_table_read_final_page)
		| (op == op_preincrement_table_read_paged) | (op == op_preincrement_table_read_final);
	assign is_pre = (op == op_preincrement_table_read_paged) | (op == op_preincrement_table_read_final);
	assign is_final = (op == op_table_read_final_page) | (op == op_preincrement_table_read_final);
	assign tpl_eff = is_pre ? tpl_reg + 8'h01 : tpl_reg;
	// Only two pointer-high bits reach the program array; upper bits are kept but unused
	assign tab_addr = is_final ? {`MSE_FINAL_PAGE, tpl_eff} : {tph_reg[1:0], tpl_eff};
	assign prog_word = pmem[tab_addr];
	always_comb begin
		mem_we = 1'b0;
		acc_we = 1'b0;
		flags_we = 1'b0;
		skip_hit = 1'b0;
		mem_wd = mem_rd;
		acc_wd = acc_reg;
		flags_wd = flags_reg;
		case (op)
			op_set_bit: begin
				mem_we = 1'b1;
				mem_wd = mem_rd | (8'h01 << cmd_bit_reg[2:0]);
			end
			op_skip_on_increment_zero: begin
				mem_we = 1'b1;
				mem_wd = inc_val;
				skip_hit = (inc_val == 8'h00);
			end
			op_increment_to_accumulator_skip: begin
				acc_we = 1'b1;
				acc_wd = inc_val;
				skip_hit = (inc_val == 8'h00);
			end
			op_skip_when_bit_nonzero: skip_hit = sel_bit;
			op_skip_when_nonzero: begin
				mem_we = 1'b1;
				skip_hit = (mem_rd != 8'h00);
			end
			op_skip_when_zero: begin
				mem_we = 1'b1;
				skip_hit = (mem_rd == 8'h00);
			end
			op_copy_then_skip_when_zero: begin
				acc_we = 1'b1;
				acc_wd = mem_rd;
				skip_hit = (mem_rd == 8'h00);
			end
			op_skip_when_bit_zero: skip_hit = ~sel_bit;
			op_difference_to_accumulator, op_difference_immediate: begin
				acc_we = 1'b1;
				acc_wd = sub_res;
			end
			op_difference_to_memory: begin
				mem_we = 1'b1;
				mem_wd = sub_res;
			end
			op_nibble_exchange: begin
				mem_we = 1'b1;
				mem_wd = swap_val;
			end
			op_nibble_exchange_to_accumulator: begin
				acc_we = 1'b1;
				acc_wd = swap_val;
			end
			op_table_read_paged, op_table_read_final_page,
			op_preincrement_table_read_paged, op_preincrement_table_read_final: begin
				mem_we = 1'b1;
				mem_wd = prog_word[7:0];
			end
			op_exclusive_or_to_accumulator, op_exclusive_or_immediate: begin
				acc_we = 1'b1;
				acc_wd = acc_reg ^ ((op == op_exclusive_or_immediate) ? cmd_imm_reg : mem_rd);
				flags_we = 1'b1;
				flags_wd[`MSE_FLG_ZERO] = (acc_wd == 8'h00);
			end
			op_exclusive_or_to_memory: begin
				mem_we = 1'b1;
				mem_wd = acc_reg ^ mem_rd;
				flags_we = 1'b1;
				flags_wd[`MSE_FLG_ZERO] = (mem_wd == 8'h00);
			end
			default: ;
		endcase
		if (is_sub) begin
			flags_we = 1'b1;
			flags_wd[`MSE_FLG_CARRY] = ~diff9[8];
			flags_wd[`MSE_FLG_HALF] = ~half5[4];
			flags_wd[`MSE_FLG_ZERO] = (sub_res == 8'h00);
			flags_wd[`MSE_FLG_WRAP] = (acc_reg[7] ^ sub_opnd[7]) & (acc_reg[7] ^ sub_res[7]);
			flags_wd[`MSE_FLG_SCMP] = ~(sub_res[7] ^ flags_wd[`MSE_FLG_WRAP]);
			flags_wd[`MSE_FLG_CHZ] = (sub_res == 8'h00);
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_reg <= st_idle;
		end else begin
			case (state_reg)
				st_idle: if (start_cmd) state_reg <= st_exec;
				st_exec: state_reg <= skip_hit ? st_dummy : st_idle;
				st_dummy: state_reg <= st_idle;
				default: state_reg <= st_idle;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			skip_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (state_reg == st_exec) begin
				skip_reg <= skip_hit;
				if (!skip_hit) done_reg <= 1'b1;
			end else if (state_reg == st_dummy) begin
				done_reg <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Architectural state
	// ---------------------------------------------------------------
	logic exec_now;
	assign exec_now = (state_reg == st_exec);
	always_ff @(posedge clk_sys_in) begin
		if (exec_now && mem_we) begin
			dmem[cmd_addr_reg] <= mem_wd;
		end else if (wr_go && in_dwin && wb_sel_in[0]) begin
			dmem[dwin_idx] <= wb_dat_in[7:0];
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (wr_go && wb_adr_in == `MSE_ADR_PDATA) begin
			pmem[paddr_reg] <= {lane(pmem[paddr_reg][15:8], wb_sel_in[1], wb_dat_in[15:8]),
				lane(pmem[paddr_reg][7:0], wb_sel_in[0], wb_dat_in[7:0])};
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			acc_reg <= `MSE_RST_BYTE;
			flags_reg <= `MSE_RST_FLAGS;
		end else if (exec_now) begin
			if (acc_we) acc_reg <= acc_wd;
			if (flags_we) flags_reg <= flags_wd;
		end else if (wr_go && wb_sel_in[0]) begin
			if (wb_adr_in == `MSE_ADR_ACC) acc_reg <= wb_dat_in[7:0];
			if (wb_adr_in == `MSE_ADR_FLAGS) flags_reg <= wb_dat_in[5:0];
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tpl_reg <= `MSE_RST_BYTE;
			tph_reg <= `MSE_RST_BYTE;
			tbh_reg <= `MSE_RST_BYTE;
		end else if (exec_now && is_tab) begin
			tpl_reg <= tpl_eff;
			tbh_reg <= prog_word[15:8];
		end else if (wr_go && wb_sel_in[0]) begin
			if (wb_adr_in == `MSE_ADR_TPL) tpl_reg <= wb_dat_in[7:0];
			if (wb_adr_in == `MSE_ADR_TPH) tph_reg <= wb_dat_in[7:0];
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cmd_op_reg <= `MSE_RST_BYTE;
			cmd_bit_reg <= `MSE_RST_BYTE;
			cmd_addr_reg <= `MSE_RST_BYTE;
			cmd_imm_reg <= `MSE_RST_BYTE;
			paddr_reg <= 10'h000;
		end else if (wr_go) begin
			if (wb_adr_in == `MSE_ADR_CMD) begin
				cmd_op_reg <= lane(cmd_op_reg, wb_sel_in[0], wb_dat_in[7:0]);
				cmd_bit_reg <= lane(cmd_bit_reg, wb_sel_in[1], wb_dat_in[15:8]);
				cmd_addr_reg <= lane(cmd_addr_reg, wb_sel_in[2], wb_dat_in[23:16]);
				cmd_imm_reg <= lane(cmd_imm_reg, wb_sel_in[3], wb_dat_in[31:24]);
			end
			if (wb_adr_in == `MSE_ADR_PADDR && wb_sel_in[0]) paddr_reg[7:0] <= wb_dat_in[7:0];
			if (wb_adr_in == `MSE_ADR_PADDR && wb_sel_in[1]) paddr_reg[9:8] <= wb_dat_in[9:8];
		end
	end

	// ---------------------------------------------------------------
	// Bus answer
	// ---------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (in_dwin) begin
			rd_mux[7:0] = dmem[dwin_idx];
		end else begin
			case (wb_adr_in)
				`MSE_ADR_CMD: rd_mux = {cmd_imm_reg, cmd_addr_reg, cmd_bit_reg, cmd_op_reg};
				`MSE_ADR_ACC: rd_mux[7:0] = acc_reg;
				`MSE_ADR_FLAGS: rd_mux[5:0] = flags_reg;
				`MSE_ADR_TPL: rd_mux[7:0] = tpl_reg;
				`MSE_ADR_TPH: rd_mux[7:0] = tph_reg;
				`MSE_ADR_TBH: rd_mux[7:0] = tbh_reg;
				`MSE_ADR_STAT: rd_mux[2:0] = {state_reg == st_dummy, skip_reg, state_reg != st_idle};
				`MSE_ADR_PADDR: rd_mux[9:0] = paddr_reg;
				`MSE_ADR_PDATA: rd_mux[15:0] = pmem[paddr_reg];
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end
	// Writes wait for idle; reads answer at once, even mid-operation
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ack_reg <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req & ~ack_reg & (~wb_we_in | (state_reg == st_idle));
			if (bus_req && !ack_reg) wb_dat_out <= rd_mux;
		end
	end

	assign wb_ack_out = ack_reg;
	assign busy_out = (state_reg != st_idle);
	assign skip_fetch_out = (state_reg == st_dummy);
	assign done_out = done_reg;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	set_bit_a: assert property (exec_now && op == op_set_bit |=>
		dmem[$past(cmd_addr_reg)] == ($past(mem_rd) | (8'h01 << $past(cmd_bit_reg[2:0]))) && $stable(flags_reg))
		else $error("bit set result wrong");
	inc_skip_a: assert property (exec_now && op == op_skip_on_increment_zero |=>
		dmem[$past(cmd_addr_reg)] == $past(inc_val) && skip_reg == ($past(mem_rd) == 8'hFF))
		else $error("increment skip wrong");
	skip_dummy_a: assert property (exec_now && skip_hit |=>
		skip_fetch_out ##1 state_reg == st_idle && done_out)
		else $error("skip did not take two cycles");
	no_skip_a: assert property (exec_now && !skip_hit |=> state_reg == st_idle && done_out)
		else $error("sequential path took extra cycle");
	inc_acc_a: assert property (exec_now && op == op_increment_to_accumulator_skip |=>
		acc_reg == $past(inc_val) && dmem[$past(cmd_addr_reg)] == $past(mem_rd))
		else $error("increment to accumulator wrong");
	bit_test_a: assert property (exec_now && (op == op_skip_when_bit_nonzero || op == op_skip_when_bit_zero) |->
		skip_hit == (sel_bit ^ (op == op_skip_when_bit_zero)))
		else $error("bit test skip wrong");
	zero_test_a: assert property (exec_now && (op == op_skip_when_zero || op == op_copy_then_skip_when_zero) |=>
		skip_reg == ($past(mem_rd) == 8'h00) && dmem[$past(cmd_addr_reg)] == $past(mem_rd))
		else $error("zero test skip wrong");
	sub_carry_a: assert property (exec_now && is_sub |=>
		flags_reg[`MSE_FLG_CARRY] == ($past(acc_reg) >= $past(sub_opnd)))
		else $error("subtract carry wrong");
	swap_mem_a: assert property (exec_now && op == op_nibble_exchange |=>
		dmem[$past(cmd_addr_reg)] == {$past(mem_rd[3:0]), $past(mem_rd[7:4])} && $stable(flags_reg))
		else $error("nibble exchange wrong");
	table_latch_a: assert property (exec_now && is_tab |=>
		tbh_reg == $past(prog_word[15:8]) && tpl_reg == $past(tpl_reg) + {7'h00, $past(is_pre)})
		else $error("table read wrong");
	xor_flags_a: assert property (exec_now && op == op_exclusive_or_to_memory |=>
		flags_reg[`MSE_FLG_ZERO] == (dmem[$past(cmd_addr_reg)] == 8'h00)
		&& flags_reg[`MSE_FLG_CARRY] == $past(flags_reg[`MSE_FLG_CARRY]))
		else $error("xor flag update wrong");

endmodule : mse_exec

`default_nettype wire

// ===== dv/mse_wb_master.sv
// Purpose: Classic Wishbone master standing in for the software side
// Assumes: One clock; ack sampled on rising edges
// Notes: lost_out latches an ack seen while no cycle is open
`timescale 1ns/10ps
`default_nettype none

module mse_wb_master (
	// Clock
	input wire logic clk_sys_in,
	// Bus
	output logic wb_cyc_out,
	output logic wb_stb_out,
	output logic wb_we_out,
	output logic [11:0] wb_adr_out,
	output logic [3:0] wb_sel_out,
	output logic [31:0] wb_dat_out,
	input wire logic [31:0] wb_dat_in,
	input wire logic wb_ack_in,
	// Status
	output logic lost_out
);
	// ---------------------------------------------------------------
	// Idle levels
	// ---------------------------------------------------------------
	initial begin
		wb_cyc_out = 1'b0;
		wb_stb_out = 1'b0;
		wb_we_out = 1'b0;
		wb_adr_out = 12'h000;
		wb_sel_out = 4'h0;
		wb_dat_out = 32'h0;
	end

	// Stray ack: the slave answered with no cycle open
	always @(posedge clk_sys_in) begin
		lost_out <= (lost_out === 1'b1) | (wb_ack_in === 1'b1 && wb_cyc_out !== 1'b1);
	end

	// ---------------------------------------------------------------
	// One classic cycle
	// ---------------------------------------------------------------
	// Waits for ack however long it takes; only the bench watchdog ends a hang
	task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys_in);
		wb_cyc_out <= 1'b1;
		wb_stb_out <= 1'b1;
		wb_we_out <= we;
		wb_adr_out <= a;
		wb_sel_out <= 4'hF;
		wb_dat_out <= d;
		do begin
			@(posedge clk_sys_in);
		end while (wb_ack_in !== 1'b1);
		q = wb_dat_in;
		wb_cyc_out <= 1'b0;
		wb_stb_out <= 1'b0;
		wb_we_out <= 1'b0;
	endtask : xfer
endmodule : mse_wb_master
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the exec unit
// Assumes: Memories loaded and inspected over the bus
// Notes: Busy and dummy cycles are counted at the ports
`timescale 1ns/10ps
`include "mse_params.svh"
`default_nettype none

module testbench
	import mse_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic clk_sys_in, rst_in, cyc, stb, we, ack, busy, skipf, done, lost;
	logic [11:0] adr;
	logic [3:0] sel;
	logic [31:0] dw, dr;
	int error_cnt = 0;
	int checks = 0;
	int bsy, dmy;
	logic [7:0] ta [4] = '{8'h10, 8'h20, 8'h80, 8'h7F};
	logic [7:0] tb [4] = '{8'h20, 8'h20, 8'h01, 8'hFF};

	mse_exec dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr),
		.wb_ack_out(ack), .busy_out(busy), .skip_fetch_out(skipf), .done_out(done));
	mse_wb_master u_bus (.clk_sys_in(clk_sys_in), .wb_cyc_out(cyc), .wb_stb_out(stb),
		.wb_we_out(we), .wb_adr_out(adr), .wb_sel_out(sel), .wb_dat_out(dw), .wb_dat_in(dr),
		.wb_ack_in(ack), .lost_out(lost));

	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	always @(posedge clk_sys_in) begin
		if (busy === 1'b1) bsy++;
		if (skipf === 1'b1) dmy++;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_bus.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_bus.xfer(1'b0, a, 32'h0, q);
		cmp(q, e);
	endtask : chk

	task automatic mw(input logic [7:0] i, input logic [7:0] v);
		wr({2'b01, i, 2'b00}, {24'h0, v});
	endtask : mw

	task automatic cm(input logic [7:0] i, input logic [7:0] v);
		chk({2'b01, i, 2'b00}, {24'h0, v});
	endtask : cm

	// Waits on done, then judges the cycle count of the operation
	task automatic op(input mse_op_e c, input logic [2:0] b, input logic [7:0] a,
		input logic [7:0] x, input logic sk);
		bsy = 0;
		dmy = 0;
		wr(`MSE_ADR_CMD, {x, a, 5'h00, b, 3'h0, c});
		while (done !== 1'b1) begin
			@(posedge clk_sys_in);
		end
		cmp(32'(bsy), sk ? 32'h2 : 32'h1);
		cmp(32'(dmy), {31'h0, sk});
	endtask : op

	function automatic logic [31:0] sf(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		logic v;
		r = a - b;
		v = (a[7] != b[7]) && (r[7] != a[7]);
		return {26'h0, r == 8'h00, ~(r[7] ^ v), v, r == 8'h00, a[3:0] >= b[3:0], a >= b};
	endfunction : sf

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		chk(`MSE_ADR_ACC, 32'h0);
		chk(`MSE_ADR_FLAGS, 32'h0);
		chk(`MSE_ADR_TPL, 32'h0);
		chk(`MSE_ADR_TBH, 32'h0);
		chk(`MSE_ADR_STAT, 32'h0);
		wr(`MSE_ADR_TBH, 32'hFF);
		chk(`MSE_ADR_TBH, 32'h0);
		wr(12'h024, 32'hFFFF);
		chk(12'h024, 32'h0);
		op(mse_op_e'(5'h14), 3'h0, 8'h00, 8'h00, 1'b0);
	endtask : t_reset

	task automatic t_bits;
		wr(`MSE_ADR_FLAGS, 32'h3F);
		mw(8'h10, 8'h5A);
		op(op_set_bit, 3'h7, 8'h10, 8'h00, 1'b0);
		cm(8'h10, 8'hDA);
		chk(`MSE_ADR_FLAGS, 32'h3F);
		mw(8'h11, 8'hFF);
		op(op_skip_on_increment_zero, 3'h0, 8'h11, 8'h00, 1'b1);
		cm(8'h11, 8'h00);
		op(op_skip_on_increment_zero, 3'h0, 8'h11, 8'h00, 1'b0);
		cm(8'h11, 8'h01);
		chk(`MSE_ADR_FLAGS, 32'h3F);
		mw(8'h12, 8'hFF);
		op(op_increment_to_accumulator_skip, 3'h0, 8'h12, 8'h00, 1'b1);
		chk(`MSE_ADR_ACC, 32'h0);
		cm(8'h12, 8'hFF);
		mw(8'h13, 8'h04);
		op(op_skip_when_bit_nonzero, 3'h2, 8'h13, 8'h00, 1'b1);
		chk(`MSE_ADR_STAT, 32'h2);
		op(op_skip_when_bit_nonzero, 3'h3, 8'h13, 8'h00, 1'b0);
		op(op_skip_when_bit_zero, 3'h2, 8'h13, 8'h00, 1'b0);
		op(op_skip_when_bit_zero, 3'h3, 8'h13, 8'h00, 1'b1);
		cm(8'h13, 8'h04);
	endtask : t_bits

	task automatic t_bytes(input logic [7:0] v);
		logic z;
		z = (v == 8'h00);
		mw(8'h14, v);
		wr(`MSE_ADR_ACC, 32'h55);
		op(op_skip_when_nonzero, 3'h0, 8'h14, 8'h00, ~z);
		op(op_skip_when_zero, 3'h0, 8'h14, 8'h00, z);
		cm(8'h14, v);
		op(op_copy_then_skip_when_zero, 3'h0, 8'h14, 8'h00, z);
		chk(`MSE_ADR_ACC, {24'h0, v});
	endtask : t_bytes

	// Every operand pair runs through all three subtract forms
	task automatic t_sub;
		for (int i = 0; i < 4; i++) begin
			wr(`MSE_ADR_ACC, {24'h0, ta[i]});
			mw(8'h15, tb[i]);
			op(op_difference_to_accumulator, 3'h0, 8'h15, 8'h00, 1'b0);
			chk(`MSE_ADR_ACC, {24'h0, 8'(ta[i] - tb[i])});
			chk(`MSE_ADR_FLAGS, sf(ta[i], tb[i]));
			wr(`MSE_ADR_ACC, {24'h0, ta[i]});
			op(op_difference_to_memory, 3'h0, 8'h15, 8'h00, 1'b0);
			cm(8'h15, 8'(ta[i] - tb[i]));
			chk(`MSE_ADR_FLAGS, sf(ta[i], tb[i]));
			op(op_difference_immediate, 3'h0, 8'h15, tb[i], 1'b0);
			chk(`MSE_ADR_ACC, {24'h0, 8'(ta[i] - tb[i])});
			chk(`MSE_ADR_FLAGS, sf(ta[i], tb[i]));
		end
	endtask : t_sub

	task automatic t_swap;
		wr(`MSE_ADR_FLAGS, 32'h15);
		mw(8'h16, 8'h3C);
		op(op_nibble_exchange, 3'h0, 8'h16, 8'h00, 1'b0);
		cm(8'h16, 8'hC3);
		op(op_nibble_exchange_to_accumulator, 3'h0, 8'h16, 8'h00, 1'b0);
		chk(`MSE_ADR_ACC, 32'h3C);
		cm(8'h16, 8'hC3);
		chk(`MSE_ADR_FLAGS, 32'h15);
	endtask : t_swap

	task automatic t_table(input mse_op_e c, input logic [31:0] p, input logic [15:0] w);
		wr(`MSE_ADR_TPL, 32'h05);
		op(c, 3'h0, 8'h17, 8'h00, 1'b0);
		cm(8'h17, w[7:0]);
		chk(`MSE_ADR_TBH, {24'h0, w[15:8]});
		chk(`MSE_ADR_TPL, p);
	endtask : t_table

	task automatic t_xor;
		wr(`MSE_ADR_FLAGS, 32'h3B);
		wr(`MSE_ADR_ACC, 32'h5A);
		mw(8'h18, 8'h5A);
		op(op_exclusive_or_to_accumulator, 3'h0, 8'h18, 8'h00, 1'b0);
		chk(`MSE_ADR_ACC, 32'h0);
		chk(`MSE_ADR_FLAGS, 32'h3F);
		wr(`MSE_ADR_ACC, 32'h0F);
		mw(8'h18, 8'hF0);
		op(op_exclusive_or_to_memory, 3'h0, 8'h18, 8'h00, 1'b0);
		cm(8'h18, 8'hFF);
		chk(`MSE_ADR_FLAGS, 32'h3B);
		op(op_exclusive_or_immediate, 3'h0, 8'h18, 8'h0F, 1'b0);
		chk(`MSE_ADR_ACC, 32'h0);
	endtask : t_xor

	// ---------------------------------------------------------------
	// Verdict and main sequence
	// ---------------------------------------------------------------
	task automatic final_report;
		if (lost === 1'b1) error_cnt++;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	initial begin
		#(20 * 20000);
		error_cnt++;
		final_report();
	end

	initial begin
		rst_in = 1'b1;
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		t_reset();
		t_bits();
		t_bytes(8'h00);
		t_bytes(8'h80);
		t_sub();
		t_swap();
		// Page 1 for paged reads, page 3 for final page
		wr(`MSE_ADR_TPH, 32'h01);
		for (int i = 0; i < 4; i++) begin
			wr(`MSE_ADR_PADDR, {22'h0, i[1], 1'b1, 6'h01, i[0], ~i[0]});
			wr(`MSE_ADR_PDATA, {16'h0, 16'hA1B2 + 16'(i * 16'h1111)});
		end
		t_table(op_table_read_paged, 32'h05, 16'hA1B2);
		t_table(op_table_read_final_page, 32'h05, 16'hC3D4);
		t_table(op_preincrement_table_read_paged, 32'h06, 16'hB2C3);
		t_table(op_preincrement_table_read_final, 32'h06, 16'hD4E5);
		t_xor();
		final_report();
	end
endmodule : testbench
`default_nettype wire
